/* File: rtl/host_port_params.svh */
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// ----------------------------------------------------------------
// Interface-select strap encodings {interface_select_a, _b}
// ----------------------------------------------------------------
`define STRAP_SERIAL      2'h0
`define STRAP_I2C         2'h1
`define STRAP_PAR_ENABLE  2'h2
`define STRAP_PAR_SPLIT   2'h3

// ----------------------------------------------------------------
// Pin positions on the host data bus
// ----------------------------------------------------------------
`define BIT_SCLK          0
`define BIT_SERIAL_DATA_INPUT          1
`define BIT_SDA_OUT       2

// ----------------------------------------------------------------
// Serial and two-wire framing
// ----------------------------------------------------------------
`define BITS_PER_BYTE     4'h8
`define ACK_SLOT          4'h9
`define I2C_ADDR_BASE     6'h15
`define CTRL_CO_BIT       7
`define CTRL_DC_BIT       6

// ----------------------------------------------------------------
// Receive buffer
// ----------------------------------------------------------------
`define FIFO_DEPTH        8
`define FIFO_WIDTH        9

`endif

/* File: rtl/host_port_pkg.sv */
package host_port_pkg;

  typedef enum logic [1:0] {
    MODE_SERIAL,
    MODE_I2C,
    MODE_PAR_ENABLE,
    MODE_PAR_SPLIT
  } port_mode_e;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_CTRL,
    I2C_DATA,
    I2C_IGNORE
  } i2c_state_e;

  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } host_byte_s;

endpackage : host_port_pkg

/* File: rtl/display_host_pin_interface.sv */
`timescale 1ns/1ps
`include "host_port_params.svh"

// ----------------------------------------------------------------
// Receive buffer
// ----------------------------------------------------------------
module host_byte_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_push;
  logic             do_pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (do_pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : host_byte_fifo

module display_host_pin_interface
  import host_port_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       init_reset_n,
  input  wire logic       interface_select_a,
  input  wire logic       interface_select_b,
  input  wire logic       chip_select_n,
  input  wire logic       enable_strobe,
  input  wire logic       direction_strobe,
  input  wire logic       data_command_select,
  input  wire logic [7:0] host_data_bus_in,
  output logic      [7:0] host_data_bus_out,
  output logic      [7:0] host_data_bus_oe_n,
  input  wire logic [7:0] read_byte,
  output logic            read_taken,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output host_byte_s      rx_byte,
  output logic            rx_dropped,
  output port_mode_e      active_mode
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    port_mode_e  mode;
    logic        prev_wr;
    logic        prev_rd;
    logic        prev_scl;
    logic        prev_sda;
    host_byte_s  wr_hold;
    logic [7:0]  dout;
    logic [7:0]  oe_n;
    logic [7:0]  shift;
    logic [3:0]  bit_cnt;
    i2c_state_e  i2c;
    logic        ctrl_co;
    logic        ctrl_dc;
    logic        push;
    host_byte_s  push_byte;
    logic        dropped;
    logic        read_done;
  } port_state_s;

  port_state_s state;
  port_state_s next_state;
  logic        port_reset;
  logic        fifo_ready;
  logic        wr_cond;
  logic        rd_cond;
  logic        scl;
  logic        sda;
  logic [7:0]  got;

  assign port_reset = srst || !init_reset_n;
  assign scl        = host_data_bus_in[`BIT_SCLK];
  assign sda        = host_data_bus_in[`BIT_SERIAL_DATA_INPUT];

  function automatic port_mode_e strap_mode(input logic [1:0] s);
    case (s)
      `STRAP_SERIAL:     strap_mode = MODE_SERIAL;
      `STRAP_I2C:        strap_mode = MODE_I2C;
      `STRAP_PAR_ENABLE: strap_mode = MODE_PAR_ENABLE;
      default:           strap_mode = MODE_PAR_SPLIT;
    endcase
  endfunction : strap_mode

  // ----------------------------------------------------------------
  // Strobe qualification
  // ----------------------------------------------------------------
  always_comb begin
    wr_cond = 1'b0;
    rd_cond = 1'b0;
    case (state.mode)
      MODE_PAR_ENABLE: begin
        wr_cond = enable_strobe && !chip_select_n && !direction_strobe;
        rd_cond = enable_strobe && !chip_select_n && direction_strobe;
      end
      MODE_PAR_SPLIT: begin
        wr_cond = !direction_strobe && !chip_select_n;
        rd_cond = !enable_strobe && !chip_select_n;
      end
      default: begin
        wr_cond = 1'b0;
        rd_cond = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state           = state;
    next_state.push      = 1'b0;
    next_state.dropped   = 1'b0;
    next_state.read_done = 1'b0;
    next_state.prev_wr   = wr_cond;
    next_state.prev_rd   = rd_cond;
    next_state.prev_scl  = scl;
    next_state.prev_sda  = sda;
    got                  = {state.shift[6:0], sda};

    case (state.mode)
      MODE_PAR_ENABLE, MODE_PAR_SPLIT: begin
        // Keep sampling while the strobe stands; bus is settled at its end
        if (wr_cond) begin
          next_state.wr_hold = '{is_data: data_command_select, value: host_data_bus_in};
        end
        if (state.prev_wr && !wr_cond) begin
          next_state.push      = 1'b1;
          next_state.push_byte = state.wr_hold;
        end
        if (rd_cond && !state.prev_rd) begin
          next_state.dout = read_byte;
          next_state.oe_n = 8'h00;
        end
        if (!rd_cond) begin
          next_state.oe_n = 8'hFF;
        end
        if (state.prev_rd && !rd_cond) begin
          next_state.read_done = 1'b1;
        end
      end
      MODE_SERIAL: begin
        next_state.oe_n = 8'hFF;
        if (chip_select_n) begin
          next_state.bit_cnt = '0;
        end else if (scl && !state.prev_scl) begin
          next_state.shift = got;
          if (state.bit_cnt == `BITS_PER_BYTE - 4'h1) begin
            next_state.bit_cnt   = '0;
            next_state.push      = 1'b1;
            next_state.push_byte = '{is_data: data_command_select, value: got};
          end else begin
            next_state.bit_cnt = state.bit_cnt + 4'h1;
          end
        end
      end
      default: begin
        if (chip_select_n) begin
          next_state.i2c  = I2C_IDLE;
          next_state.oe_n = 8'hFF;
        end else if (scl && state.prev_scl && state.prev_sda && !sda) begin
          next_state.i2c     = I2C_ADDR; // Start or repeated start
          next_state.bit_cnt = '0;
          next_state.oe_n    = 8'hFF;
        end else if (scl && state.prev_scl && !state.prev_sda && sda) begin
          next_state.i2c  = I2C_IDLE; // Stop
          next_state.oe_n = 8'hFF;
        end else if (state.i2c != I2C_IDLE) begin
          if (scl && !state.prev_scl && state.bit_cnt < `BITS_PER_BYTE) begin
            next_state.shift   = got;
            next_state.bit_cnt = state.bit_cnt + 4'h1;
          end else if (scl && !state.prev_scl) begin
            next_state.bit_cnt = `ACK_SLOT;
          end else if (!scl && state.prev_scl && state.bit_cnt == `ACK_SLOT) begin
            next_state.oe_n    = 8'hFF; // Release acknowledge
            next_state.bit_cnt = '0;
          end else if (!scl && state.prev_scl && state.bit_cnt == `BITS_PER_BYTE) begin
            case (state.i2c)
              I2C_ADDR: begin
                // Write-only slave; address LSB comes from the D/C pin
                if (state.shift == {`I2C_ADDR_BASE, data_command_select, 1'b0}) begin
                  next_state.i2c                 = I2C_CTRL;
                  next_state.oe_n[`BIT_SDA_OUT]  = 1'b0;
                  next_state.dout[`BIT_SDA_OUT]  = 1'b0;
                end else begin
                  next_state.i2c = I2C_IGNORE;
                end
              end
              I2C_CTRL: begin
                next_state.ctrl_co             = state.shift[`CTRL_CO_BIT];
                next_state.ctrl_dc             = state.shift[`CTRL_DC_BIT];
                next_state.i2c                 = I2C_DATA;
                next_state.oe_n[`BIT_SDA_OUT]  = 1'b0;
                next_state.dout[`BIT_SDA_OUT]  = 1'b0;
              end
              I2C_DATA: begin
                // A full buffer is refused with a not-acknowledge
                if (fifo_ready) begin
                  next_state.push                = 1'b1;
                  next_state.push_byte           = '{is_data: state.ctrl_dc, value: state.shift};
                  next_state.oe_n[`BIT_SDA_OUT]  = 1'b0;
                  next_state.dout[`BIT_SDA_OUT]  = 1'b0;
                end
                next_state.i2c = state.ctrl_co ? I2C_CTRL : I2C_DATA;
              end
              default: begin
                next_state.i2c = I2C_IGNORE;
              end
            endcase
          end
        end
      end
    endcase

    // Parallel and serial hosts cannot be stalled; overflow is flagged
    if (state.push && !fifo_ready) begin
      next_state.dropped = 1'b1;
    end

    if (port_reset) begin
      next_state      = '0;
      next_state.mode = strap_mode({interface_select_a, interface_select_b});
      next_state.oe_n = 8'hFF;
      next_state.i2c  = I2C_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    state <= next_state;
  end

  // ----------------------------------------------------------------
  // Buffer and outputs
  // ----------------------------------------------------------------
  host_byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) rx_fifo (
    .ref_clk   (ref_clk),
    .srst      (port_reset),
    .in_valid  (state.push),
    .in_ready  (fifo_ready),
    .in_data   (state.push_byte),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_byte)
  );

  assign host_data_bus_out  = state.dout;
  assign host_data_bus_oe_n = state.oe_n;
  assign read_taken         = state.read_done;
  assign rx_dropped         = state.dropped;
  assign active_mode        = state.mode;

endmodule : display_host_pin_interface

/* File: tb/host_port_sva.sv */
`timescale 1ns/1ps
module host_port_sva
  import host_port_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       init_reset_n,
  input wire logic       chip_select_n,
  input wire logic       enable_strobe,
  input wire logic       direction_strobe,
  input wire logic [7:0] host_data_bus_out,
  input wire logic [7:0] host_data_bus_oe_n,
  input wire logic [7:0] read_byte,
  input wire logic       read_taken,
  input wire logic       rx_valid,
  input wire port_mode_e active_mode
);
  logic rd_en, rd_sp, wr_any;
  assign rd_en = active_mode == MODE_PAR_ENABLE && enable_strobe && !chip_select_n
                 && direction_strobe;
  assign rd_sp = active_mode == MODE_PAR_SPLIT && !enable_strobe && !chip_select_n;
  assign wr_any = !chip_select_n && !direction_strobe && (active_mode == MODE_PAR_SPLIT
                  || (active_mode == MODE_PAR_ENABLE && enable_strobe));
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst || !init_reset_n);
  sequence s_drive;
    host_data_bus_oe_n == 8'h00 && host_data_bus_out == $past(read_byte);
  endsequence
  sequence s_release;
    host_data_bus_oe_n == 8'hFF && read_taken;
  endsequence
  a_read_enable: assert property ($rose(rd_en) |=> s_drive)
    else $error("enable form read not driven");
  a_read_split: assert property ($rose(rd_sp) |=> s_drive)
    else $error("split form read not driven");
  a_read_release: assert property ($fell(rd_en || rd_sp) |=> s_release)
    else $error("bus not released after read");
  a_write_push: assert property ($fell(wr_any) && !rx_valid |-> ##2 rx_valid)
    else $error("written byte not buffered");
  a_serial_quiet: assert property (active_mode == MODE_SERIAL
    |-> host_data_bus_oe_n == 8'hFF)
    else $error("bus driven in serial mode");
  a_i2c_pins: assert property (active_mode == MODE_I2C
    |-> (host_data_bus_oe_n | 8'h04) == 8'hFF)
    else $error("wrong line driven in two-wire mode");
  a_cs_quiet: assert property (chip_select_n [*2] |-> host_data_bus_oe_n == 8'hFF)
    else $error("bus driven while deselected");
  a_write_quiet: assert property ((active_mode == MODE_PAR_ENABLE && !direction_strobe) [*2]
    |-> host_data_bus_oe_n == 8'hFF)
    else $error("bus driven during write direction");
endmodule : host_port_sva

bind display_host_pin_interface host_port_sva chk (.ref_clk, .srst, .init_reset_n,
  .chip_select_n, .enable_strobe, .direction_strobe, .host_data_bus_out,
  .host_data_bus_oe_n, .read_byte, .read_taken, .rx_valid, .active_mode);

/* File: tb/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       ref_clk,
  input  wire logic       split,
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe_n,
  output logic            cs_n,
  output logic            strobe_e,
  output logic            strobe_dir,
  output logic            dc,
  output logic [7:0]      bus
);
  logic [7:0] drv = 8'h00;
  logic [7:0] last = 8'h00;
  logic       rel = 1'b0;
  logic       tied = 1'b0;
  logic [7:0] mix;
  initial begin
    cs_n = 1'b1;
    strobe_e = 1'b0;
    strobe_dir = 1'b0;
    dc = 1'b0;
  end
  // Once a read sets rel, released lines flip each cycle so a stale level never passes
  always @(posedge ref_clk) last <= bus;
  assign mix = (dev_oe_n & (rel ? ~last : drv)) | (~dev_oe_n & dev_out);
  // Two-wire: device bit 2 and host bit 1 form one wired-and line
  assign bus = {mix[7:2], mix[1] & (!tied | dev_oe_n[2] | dev_out[2]), mix[0]};
  task automatic idle();
    cs_n = 1'b1;
    strobe_e = split;
    strobe_dir = split;
  endtask : idle
  task automatic par_write(input logic sel, input logic is_data, input logic [7:0] b);
    @(negedge ref_clk);
    cs_n = !sel;
    dc = is_data;
    drv = b;
    rel = 1'b0;
    strobe_e = 1'b1;
    strobe_dir = 1'b0;
    repeat (2) @(negedge ref_clk);
    idle();
    @(negedge ref_clk);
  endtask : par_write
  task automatic par_read(output logic [7:0] v);
    @(negedge ref_clk);
    cs_n = 1'b0;
    rel = 1'b1;
    strobe_dir = 1'b1;
    @(negedge ref_clk);
    strobe_e = !split;
    repeat (2) @(negedge ref_clk);
    v = bus;
    idle();
  endtask : par_read
  task automatic ser_byte(input logic is_data, input logic [7:0] b);
    rel = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(negedge ref_clk);
      cs_n = 1'b0;
      dc = is_data;
      drv = {6'h00, b[i], 1'b0};
      @(negedge ref_clk);
      drv[0] = 1'b1;
    end
    @(negedge ref_clk);
    drv = 8'h00;
    repeat (2) @(negedge ref_clk);
    cs_n = 1'b1;
  endtask : ser_byte
  task automatic i2c_clock(input logic b, output logic seen);
    @(negedge ref_clk);
    drv = {6'h00, b, 1'b0};
    @(negedge ref_clk);
    drv[0] = 1'b1;
    @(negedge ref_clk);
    seen = bus[1];
  endtask : i2c_clock
  task automatic i2c_frame(input logic sa, input logic [23:0] bytes, output logic [2:0] nak);
    logic        s;
    logic [23:0] sr;
    sr = bytes;
    @(negedge ref_clk);
    cs_n = 1'b0;
    dc = sa;
    rel = 1'b0;
    tied = 1'b1;
    drv = 8'h03;
    @(negedge ref_clk);
    drv = 8'h01;
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 8; i++) begin
        i2c_clock(sr[23], s);
        sr = {sr[22:0], 1'b0};
      end
      // Released line reads low only if the device acknowledges
      i2c_clock(1'b1, s);
      nak[2 - k] = s;
    end
    @(negedge ref_clk);
    drv = 8'h00;
    @(negedge ref_clk);
    drv = 8'h01;
    @(negedge ref_clk);
    drv = 8'h03;
    @(negedge ref_clk);
    cs_n = 1'b1;
    tied = 1'b0;
  endtask : i2c_frame
endmodule : host_bus_model

/* File: tb/display_host_pin_interface_test.sv */
`timescale 1ns/1ps
`include "host_port_params.svh"
module display_host_pin_interface_test;
  import host_port_pkg::*;
  logic       ref_clk = 0, srst = 1, init_reset_n = 1, rx_ready = 0, split = 0;
  logic       strap_a = 0, strap_b = 0;
  logic [7:0] read_byte = 8'h00, v;
  logic [7:0] host_data_bus_out, host_data_bus_oe_n, bus;
  logic       cs_n, e, dir, dc, read_taken, rx_valid, rx_dropped;
  host_byte_s rx_byte;
  port_mode_e active_mode;
  int         fails = 0, n_tests = 0, n_drop = 0;
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rx_dropped === 1'b1) n_drop <= n_drop + 1;
  host_bus_model hm (.ref_clk, .split, .dev_out(host_data_bus_out),
    .dev_oe_n(host_data_bus_oe_n), .cs_n, .strobe_e(e), .strobe_dir(dir), .dc, .bus);
  display_host_pin_interface dut (.ref_clk, .srst, .init_reset_n,
    .interface_select_a(strap_a), .interface_select_b(strap_b), .chip_select_n(cs_n),
    .enable_strobe(e), .direction_strobe(dir), .data_command_select(dc),
    .host_data_bus_in(bus), .host_data_bus_out, .host_data_bus_oe_n, .read_byte,
    .read_taken, .rx_valid, .rx_ready, .rx_byte, .rx_dropped, .active_mode);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic restart(input logic [1:0] strap, input logic pin, input logic sp);
    @(negedge ref_clk);
    {strap_a, strap_b} = strap;
    split = sp;
    #0 hm.idle();
    if (pin) init_reset_n = 1'b0;
    else srst = 1'b1;
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    init_reset_n = 1'b1;
    @(negedge ref_clk);
    check("mode", {7'h00, active_mode}, {7'h00, strap});
  endtask : restart
  task automatic pop(input logic [8:0] exp);
    int k;
    k = 0;
    while (rx_valid !== 1'b1 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
    if (rx_valid !== 1'b1) begin
      fails++;
      stop_test();
    end else begin
      check("rx_byte", rx_byte, exp);
      rx_ready = 1'b1;
      @(negedge ref_clk);
      rx_ready = 1'b0;
    end
  endtask : pop
  task automatic read_back(input logic [7:0] b);
    read_byte = b;
    hm.par_read(v);
    check("read data", {1'b0, v}, {1'b0, b});
    @(negedge ref_clk);
    check("read taken", {8'h00, read_taken}, 9'h001);
  endtask : read_back
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_enable();
    int drop_base;
    restart(2'h2, 1'b0, 1'b0);
    hm.par_write(1'b1, 1'b0, 8'h3C);
    hm.par_write(1'b1, 1'b1, 8'hC3);
    pop({1'b0, 8'h3C});
    pop({1'b1, 8'hC3});
    read_back(8'h5A);
    drop_base = n_drop;
    // Ninth byte finds the buffer full and is lost
    for (int i = 0; i < 9; i++) hm.par_write(1'b1, 1'b1, 8'(i));
    repeat (3) @(negedge ref_clk);
    check("dropped", 9'(n_drop - drop_base), 9'h001);
    for (int i = 0; i < 8; i++) pop({1'b1, 8'(i)});
    repeat (3) @(negedge ref_clk);
    check("drained", {8'h00, rx_valid}, 9'h000);
    $display("enable form test done");
  endtask : t_enable
  task automatic t_split();
    restart(2'h3, 1'b1, 1'b1);
    hm.par_write(1'b0, 1'b1, 8'h99);
    repeat (4) @(negedge ref_clk);
    check("deselected", {8'h00, rx_valid}, 9'h000);
    hm.par_write(1'b1, 1'b0, 8'h81);
    pop({1'b0, 8'h81});
    read_back(8'hA7);
    $display("split form test done");
  endtask : t_split
  task automatic t_serial();
    restart(2'h0, 1'b0, 1'b0);
    hm.ser_byte(1'b1, 8'hA5);
    pop({1'b1, 8'hA5});
    hm.ser_byte(1'b0, 8'h0F);
    pop({1'b0, 8'h0F});
    $display("serial test done");
  endtask : t_serial
  task automatic t_i2c();
    logic [2:0] nak;
    restart(2'h1, 1'b0, 1'b0);
    hm.i2c_frame(1'b1, {`I2C_ADDR_BASE, 2'h2, 8'h40, 8'h6E}, nak);
    check("i2c acks", {6'h00, nak}, 9'h000);
    pop({1'b1, 8'h6E});
    hm.i2c_frame(1'b0, {`I2C_ADDR_BASE, 2'h2, 8'h40, 8'h6E}, nak);
    check("i2c foreign acks", {6'h00, nak}, 9'h007);
    repeat (4) @(negedge ref_clk);
    check("i2c ignored", {8'h00, rx_valid}, 9'h000);
    $display("two-wire test done");
  endtask : t_i2c
  initial begin
    t_enable();
    t_split();
    t_serial();
    t_i2c();
    stop_test();
  end
endmodule : display_host_pin_interface_test
